// ---- fpec_map.vh ----
`ifndef FPEC_MAP_VH
`define FPEC_MAP_VH

// ------------------------------------------------------------------
// register indices (port address, one register per index)
// ------------------------------------------------------------------
`define FPEC_ADDR_MODE     4'h0
`define FPEC_ADDR_STATUS   4'h1
`define FPEC_ADDR_BLOCK    4'h2
`define FPEC_ADDR_POWER    4'h3
`define FPEC_ADDR_GATE     4'h4
`define FPEC_ADDR_GEOM     4'h5

// ------------------------------------------------------------------
// mode control field positions
// ------------------------------------------------------------------
`define FPEC_BIT_RSVD      7
`define FPEC_BIT_UNLOCK    6
`define FPEC_BIT_ESU       5
`define FPEC_BIT_PSU       4
`define FPEC_BIT_ECHK      3
`define FPEC_BIT_PCHK      2
`define FPEC_BIT_ERASE     1
`define FPEC_BIT_PROG      0

// gate register enable bit, power register disable bit
`define FPEC_BIT_GATE_EN   7
`define FPEC_BIT_PDWN_DIS  7

// ------------------------------------------------------------------
// reset values and masks
// ------------------------------------------------------------------
`define FPEC_RST_MODE      8'h00
`define FPEC_RST_BLOCK     8'h00
`define FPEC_RST_POWER     8'h00
`define FPEC_RST_GATE      8'h00
`define FPEC_MODE_MASK     8'h7f
`define FPEC_BLOCK_MASK    8'h1f

// ------------------------------------------------------------------
// array geometry
// ------------------------------------------------------------------
`define FPEC_UNIT_MASK     16'h007f
`define FPEC_SMALL_BLOCKS  16'h1000
`define FPEC_BIG_END       16'h7fff
`define FPEC_SMALL_END     16'h3fff

`endif

// ---- fpec_sync.v ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// two-stage synchroniser for a level from outside the clock domain
// ------------------------------------------------------------------
module fpec_sync (
  input  wire mclk,
  input  wire reset,
  input  wire din,
  output reg  dout
);
  reg stage1;  // first stage, read only by dout

  // first flop feeds only the second
  always @(posedge mclk) begin
    if (reset) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule

// ---- fpec_block_decode.v ----
`include "fpec_map.vh"
`timescale 1ns/1ps
// ------------------------------------------------------------------
// maps a flash address to erase block and programming unit facts
// ------------------------------------------------------------------
module fpec_block_decode #(
  parameter BIG_ARRAY = 1
) (
  input  wire [15:0] addr,
  output reg  [4:0]  block_onehot,
  output reg         unit_start,
  output reg         in_range
);
  // 4 x 1 kbyte blocks, then one large block to the array end
  always @* begin
    block_onehot = 5'h00;
    in_range     = 1'b1;
    unit_start   = ((addr & `FPEC_UNIT_MASK) == 16'h0000);
    if (addr < `FPEC_SMALL_BLOCKS) begin
      block_onehot = 5'h01 << addr[11:10];
    end else if (addr <= (BIG_ARRAY ? `FPEC_BIG_END : `FPEC_SMALL_END)) begin
      block_onehot = 5'h10;
    end else begin
      in_range     = 1'b0;  // beyond the array end
    end
  end
endmodule

// ---- fpec_control.v ----
`include "fpec_map.vh"
`timescale 1ns/1ps
// Behaviour
// - large array: 4x1k then 28k erase
// - small array: 4x1k then 12k erase
// - programming in 128-byte aligned units
// - bit 7 reserved, reads zero
// - unlock bit enables program and erase
// - unlock low blocks setting other bits
// - bit 5 enters erase setup state
// - bit 4 enters program setup state
// - bit 3 selects erase-verify mode
// - bit 2 selects program-verify mode
// - erase needs unlock and erase setup
// - program needs unlock and program setup
// - unlock low holds block select zero
// - registers other than the gate reachable only with access enable
module fpec_control #(
  parameter BIG_ARRAY = 1  // 1: 32 kbyte array, 0: 16 kbyte array
) (
  input  wire        mclk,
  input  wire        reset,
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire [15:0] flash_addr,
  input  wire        flash_error_pin,
  output reg         erase_setup_out,
  output reg         program_setup_out,
  output reg         erase_mode,
  output reg         program_mode,
  output reg         erase_check_mode,
  output reg         program_check_mode,
  output reg  [4:0]  erase_blocks,
  output reg         power_down_disable,
  output reg         unit_aligned,
  output reg         addr_valid
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  reg  [7:0] flash_mode_control;    // mode control, bit 7 always 0
  reg  [7:0] erase_block_select;    // one-hot block pick
  reg  [7:0] power_control;         // power-down disable in bit 7
  reg  [7:0] control_access_gate;   // access enable in bit 7
  reg        error_flag;            // sticky error, cleared by reset only
  reg  [7:0] next_mode;             // next mode control value
  reg  [7:0] next_block;            // next block select value
  wire       err_sync;              // synchronised error level
  wire [4:0] dec_block;             // decoded block of flash_addr
  wire       dec_unit;              // address opens a 128-byte unit
  wire       dec_range;             // address inside the array
  wire       unlock;                // program/erase unlock bit
  wire       control_access_enable; // gates the control registers

  assign unlock                = flash_mode_control[`FPEC_BIT_UNLOCK];
  assign control_access_enable = control_access_gate[`FPEC_BIT_GATE_EN];

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // true when at most one bit of v is set
  function onehot_or_zero;
    input [7:0] v;
    begin
      onehot_or_zero = ((v & (v - 8'h01)) == 8'h00);
    end
  endfunction

  // ------------------------------------------------------------------
  // sub-blocks
  // ------------------------------------------------------------------
  // error level arrives from the array, outside our timing
  fpec_sync u_err_sync (
    .mclk  (mclk),
    .reset (reset),
    .din   (flash_error_pin),
    .dout  (err_sync)
  );

  // address to block and unit decode
  fpec_block_decode #(
    .BIG_ARRAY (BIG_ARRAY)
  ) u_decode (
    .addr         (flash_addr),
    .block_onehot (dec_block),
    .unit_start   (dec_unit),
    .in_range     (dec_range)
  );

  // ------------------------------------------------------------------
  // next value of mode control
  // ------------------------------------------------------------------
  always @* begin
    next_mode = flash_mode_control;
    if (reg_wr && control_access_enable && reg_addr == `FPEC_ADDR_MODE) begin
      if (reg_wdata[`FPEC_BIT_UNLOCK] || unlock) begin
        // unlock already set: other bits writable
        next_mode = reg_wdata & `FPEC_MODE_MASK;
        if (!unlock) begin
          // same write that sets unlock may not set the rest
          next_mode = reg_wdata & (8'h01 << `FPEC_BIT_UNLOCK);
        end
      end else begin
        // unlock low: other bits refused
        next_mode = 8'h00;
      end
    end
  end

  // ------------------------------------------------------------------
  // next value of erase block select
  // ------------------------------------------------------------------
  always @* begin
    next_block = erase_block_select;
    if (reg_wr && control_access_enable && reg_addr == `FPEC_ADDR_BLOCK && unlock) begin
      // more than one of bits 4:0 set clears the whole register
      if (onehot_or_zero(reg_wdata & `FPEC_BLOCK_MASK)) begin
        next_block = reg_wdata & `FPEC_BLOCK_MASK;
      end else begin
        next_block = 8'h00;
      end
    end
    if (!next_mode[`FPEC_BIT_UNLOCK]) begin
      next_block = 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // register file writes
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      flash_mode_control  <= `FPEC_RST_MODE;
      erase_block_select  <= `FPEC_RST_BLOCK;
      power_control       <= `FPEC_RST_POWER;
      control_access_gate <= `FPEC_RST_GATE;
      error_flag          <= 1'b0;
    end else begin
      flash_mode_control <= next_mode;
      erase_block_select <= next_block;
      // the gate itself is always reachable, else it could never open
      if (reg_wr && reg_addr == `FPEC_ADDR_GATE) begin
        control_access_gate <= reg_wdata & (8'h01 << `FPEC_BIT_GATE_EN);
      end
      if (reg_wr && control_access_enable && reg_addr == `FPEC_ADDR_POWER) begin
        power_control <= reg_wdata & (8'h01 << `FPEC_BIT_PDWN_DIS);
      end
      // sticky: the error level wins, nothing clears it but reset
      if (err_sync) begin
        error_flag <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // read port: data one cycle after the strobe
  // ------------------------------------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `FPEC_ADDR_GATE) begin
        reg_rdata <= control_access_gate;
      end else if (!control_access_enable) begin
        reg_rdata <= 8'h00;
      end else if (reg_addr == `FPEC_ADDR_MODE) begin
        reg_rdata <= flash_mode_control & `FPEC_MODE_MASK;
      end else if (reg_addr == `FPEC_ADDR_STATUS) begin
        reg_rdata <= {error_flag, 7'h00};
      end else if (reg_addr == `FPEC_ADDR_BLOCK) begin
        reg_rdata <= erase_block_select;
      end else if (reg_addr == `FPEC_ADDR_POWER) begin
        reg_rdata <= power_control;
      end else if (reg_addr == `FPEC_ADDR_GEOM) begin
        // live decode of flash_addr: range, unit start, block
        reg_rdata <= {dec_range, dec_unit, 1'b0, dec_block};
      end else begin
        reg_rdata <= 8'h00;  // unmapped
      end
    end else begin
      reg_rdata <= 8'h00;  // data stand for one cycle only
    end
  end

  // ------------------------------------------------------------------
  // mode outputs to the array
  // ------------------------------------------------------------------
  // a write clearing a bit drops the mode on the next edge; an error
  // also drops erase and program so the array is never left driven
  always @(posedge mclk) begin
    if (reset) begin
      erase_setup_out    <= 1'b0;
      program_setup_out  <= 1'b0;
      erase_mode         <= 1'b0;
      program_mode       <= 1'b0;
      erase_check_mode   <= 1'b0;
      program_check_mode <= 1'b0;
      erase_blocks       <= 5'h00;
      power_down_disable <= 1'b0;
      unit_aligned       <= 1'b0;
      addr_valid         <= 1'b0;
    end else begin
      erase_setup_out    <= unlock && flash_mode_control[`FPEC_BIT_ESU];
      program_setup_out  <= unlock && flash_mode_control[`FPEC_BIT_PSU];
      erase_check_mode   <= unlock && flash_mode_control[`FPEC_BIT_ECHK];
      program_check_mode <= unlock && flash_mode_control[`FPEC_BIT_PCHK];
      erase_mode         <= unlock && flash_mode_control[`FPEC_BIT_ESU]
                            && flash_mode_control[`FPEC_BIT_ERASE]
                            && !error_flag;
      program_mode       <= unlock && flash_mode_control[`FPEC_BIT_PSU]
                            && flash_mode_control[`FPEC_BIT_PROG]
                            && !error_flag;
      erase_blocks       <= erase_block_select[4:0];
      power_down_disable <= power_control[`FPEC_BIT_PDWN_DIS];
      unit_aligned       <= dec_unit;
      addr_valid         <= dec_range;
    end
  end

endmodule

// ---- fpec_control_properties.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// port-level checks for the flash mode control block
// ------------------------------------------------------------------
module fpec_control_properties #(
  parameter BIG_ARRAY = 1
) (
  input wire        mclk,
  input wire        reset,
  input wire [3:0]  reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire [15:0] flash_addr,
  input wire        erase_setup_out,
  input wire        program_setup_out,
  input wire        erase_mode,
  input wire        program_mode,
  input wire        erase_check_mode,
  input wire        program_check_mode,
  input wire        unit_aligned,
  input wire        addr_valid
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // last byte of the array, depends on the variant
  localparam [15:0] TOP = BIG_ARRAY ? 16'h7fff : 16'h3fff;

  property p_rsvd; reg_rd && reg_addr == 4'h0 |=> !reg_rdata[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mode bit read as one");
  property p_emode; erase_mode |-> erase_setup_out; endproperty
  a_emode: assert property (p_emode) else $error("erase without setup");
  property p_pmode; program_mode |-> program_setup_out; endproperty
  a_pmode: assert property (p_pmode) else $error("program without setup");
  // mode outputs only rise two edges after a write that set their bit
  property p_esu; $rose(erase_setup_out) |-> $past(reg_wr, 2) && ($past(reg_wdata, 2) & 8'h20) != 8'h00; endproperty
  a_esu: assert property (p_esu) else $error("erase setup rose without write");
  property p_psu; $rose(program_setup_out) |-> $past(reg_wr, 2) && ($past(reg_wdata, 2) & 8'h10) != 8'h00; endproperty
  a_psu: assert property (p_psu) else $error("program setup rose without write");
  property p_echk; $rose(erase_check_mode) |-> $past(reg_wr, 2) && ($past(reg_wdata, 2) & 8'h08) != 8'h00; endproperty
  a_echk: assert property (p_echk) else $error("erase verify rose without write");
  property p_pchk; $rose(program_check_mode) |-> $past(reg_wr, 2) && ($past(reg_wdata, 2) & 8'h04) != 8'h00; endproperty
  a_pchk: assert property (p_pchk) else $error("program verify rose without write");
  property p_rst; $fell(reset) |-> reg_rdata == 8'h00 && !erase_mode && !program_mode && !erase_check_mode; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_unit; !$past(reset) |-> unit_aligned == (($past(flash_addr) & 16'h007f) == 16'h0000); endproperty
  a_unit: assert property (p_unit) else $error("unit alignment wrong");
  property p_range; !$past(reset) |-> addr_valid == ($past(flash_addr) <= TOP); endproperty
  a_range: assert property (p_range) else $error("array range wrong");
endmodule

bind fpec_control fpec_control_properties #(.BIG_ARRAY(BIG_ARRAY)) chk_u (.mclk(mclk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .flash_addr(flash_addr), .erase_setup_out(erase_setup_out),
  .program_setup_out(program_setup_out), .erase_mode(erase_mode), .program_mode(program_mode),
  .erase_check_mode(erase_check_mode), .program_check_mode(program_check_mode),
  .unit_aligned(unit_aligned), .addr_valid(addr_valid));

// ---- fpec_control_bench.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------------
// self-checking bench for the flash mode control block
// ------------------------------------------------------------------
module fpec_control_bench;
  reg         mclk, reset, reg_wr, reg_rd, flash_error_pin;
  reg  [3:0]  reg_addr;
  reg  [7:0]  reg_wdata;
  reg  [15:0] flash_addr;
  wire [7:0]  reg_rdata;
  wire [4:0]  erase_blocks;
  wire        es, ps, em, pm, ec, pc, power_down_disable, unit_aligned, addr_valid;
  wire        small_valid;  // array range of the small variant
  // all mode outputs in one word: esu psu erase prog echk pchk blocks
  wire [10:0] modes = {es, ps, em, pm, ec, pc, erase_blocks};
  int         mismatches, num_checks, i;
  logic [15:0] tbl [8] = '{16'h0000, 16'h0480, 16'h0bff, 16'h0c81,
                           16'h1000, 16'h7f80, 16'h8000, 16'hffff};

  fpec_control #(.BIG_ARRAY(1)) dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_addr(flash_addr), .flash_error_pin(flash_error_pin), .erase_setup_out(es),
    .program_setup_out(ps), .erase_mode(em), .program_mode(pm), .erase_check_mode(ec),
    .program_check_mode(pc), .erase_blocks(erase_blocks),
    .power_down_disable(power_down_disable), .unit_aligned(unit_aligned), .addr_valid(addr_valid));

  // small array variant, only its range decode is judged
  fpec_control #(.BIG_ARRAY(0)) dut_small_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .flash_addr(flash_addr), .flash_error_pin(flash_error_pin), .erase_setup_out(),
    .program_setup_out(), .erase_mode(), .program_mode(), .erase_check_mode(),
    .program_check_mode(), .erase_blocks(), .power_down_disable(), .unit_aligned(),
    .addr_valid(small_valid));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  task chk(input logic [15:0] seen, input logic [15:0] exp, input string name);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one-cycle write strobe, released at the edge that takes it
  task wr(input [3:0] a, input [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task rd(input [3:0] a, input [7:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp, "rdata");
  endtask

  // mode outputs lag the register by one edge
  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task t_gate;
    chk(modes, 11'h000, "reset modes");
    wr(4'h0, 8'h40);
    rd(4'h0, 8'h00);
    wr(4'h4, 8'h80);
    rd(4'h0, 8'h00);
  endtask

  task t_lock;
    wr(4'h0, 8'h3f);
    rd(4'h0, 8'h00);
    wr(4'h2, 8'h01);
    rd(4'h2, 8'h00);
    settle;
    chk(modes, 11'h000, "locked modes");
  endtask

  task t_erase;
    wr(4'h0, 8'h40); wr(4'h0, 8'h60); settle;
    chk(modes, 11'h400, "erase setup");
    wr(4'h0, 8'h62); wr(4'h2, 8'h10); settle;
    chk(modes, 11'h510, "erase mode");
    rd(4'h2, 8'h10);
    wr(4'h0, 8'h60); settle;
    chk(modes, 11'h410, "erase cancel");
    wr(4'h0, 8'h00); settle;
    chk(modes, 11'h000, "relock");
    rd(4'h2, 8'h00);
  endtask

  task t_prog;
    wr(4'h0, 8'h40); wr(4'h0, 8'h41); settle;
    chk(modes, 11'h000, "program no setup");
    wr(4'h0, 8'h50); settle;
    chk(modes, 11'h200, "program setup");
    wr(4'h0, 8'h51); settle;
    chk(modes, 11'h280, "program mode");
    wr(4'h0, 8'h50); settle;
    chk(modes, 11'h200, "program cancel");
  endtask

  task t_verify;
    wr(4'h0, 8'hcc);
    rd(4'h0, 8'h4c);
    settle;
    chk(modes, 11'h060, "verify modes");
    wr(4'h0, 8'h44); settle;
    chk(modes, 11'h020, "erase verify off");
    wr(4'h0, 8'h40); settle;
    chk(modes, 11'h000, "program verify off");
  endtask

  // unit starts, block boundaries and the array end
  task t_decode;
    for (i = 0; i < 8; i++) begin
      @(posedge mclk);
      flash_addr <= tbl[i];
      settle;
      chk(unit_aligned, tbl[i][6:0] == 7'h00, "unit");
      chk(addr_valid, tbl[i] <= 16'h7fff, "range");
      chk(small_valid, tbl[i] <= 16'h3fff, "small range");
      if (tbl[i] <= 16'h7fff)
        rd(4'h5, {2'b10 | (tbl[i][6:0] == 7'h00), 1'b0,
                  tbl[i] < 16'h1000 ? 5'h01 << tbl[i][11:10] : 5'h10});
    end
  endtask

  // power bit, error lockout of erase, then a reset in mid-run
  task t_error;
    wr(4'h3, 8'h80); settle;
    chk(power_down_disable, 1'b1, "power down disable");
    wr(4'h0, 8'h40); wr(4'h0, 8'h60); wr(4'h0, 8'h62); settle;
    chk(em, 1'b1, "erase before error");
    @(posedge mclk);
    flash_error_pin <= 1'b1;
    repeat (5) @(posedge mclk);
    #1 chk(em, 1'b0, "erase after error");
    rd(4'h1, 8'h80);
    @(posedge mclk);
    flash_error_pin <= 1'b0;
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    #1 chk(modes, 11'h000, "modes after reset");
    chk(power_down_disable, 1'b0, "power after reset");
    wr(4'h4, 8'h80);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // the whole run is about 150 cycles, 2000 means a hang
  initial begin
    #20000;
    mismatches++;
    complete_run;
  end

  initial begin
    mclk = 0; reset = 1; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
    flash_addr = 0; flash_error_pin = 0;
    mismatches = 0; num_checks = 0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1;
    t_gate; t_lock; t_erase; t_prog; t_verify; t_decode; t_error;
    complete_run;
  end
endmodule
